// *** design/lowrate_frame_pkg.sv ***
// Shared constants, types and the frame check function of the frame formatter
package lowrate_frame_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned SYM_RATE_HZ  = 62_500;
  localparam int unsigned SYM_CYCLES   = CLK_HZ / SYM_RATE_HZ;
  localparam int unsigned SYNC_NIBBLES = 4;
  localparam int unsigned AVG_SYMBOLS  = 8;
  localparam int unsigned FIFO_DEPTH   = 4;

  // Register reset values and fields
  localparam logic [15:0] SFD_PATTERN_RST  = 16'ha70f;
  localparam logic [15:0] MODEM_CTRL_0_RST = 16'h0022;
  localparam logic [15:0] MODEM_CTRL_1_RST = 16'h0500;
  localparam int unsigned PRE_LSB          = 0;
  localparam int unsigned PRE_W            = 4;
  localparam logic [3:0]  PRE_DEFAULT      = 4'h2;
  localparam int unsigned AUTO_FCS_BIT     = 5;
  localparam int unsigned CORR_DETECT_THRESHOLD_LSB     = 6;
  localparam int unsigned CORR_DETECT_THRESHOLD_W       = 5;

  localparam logic [3:0]  PRE_SYMBOL  = 4'h0;
  localparam logic [3:0]  IGNORE_NIB  = 4'hf;
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  localparam logic [15:0] CRC_POLY_R  = 16'h8408;
  localparam logic [6:0]  FCS_BYTES   = 7'h02;

  typedef struct packed {
    logic [1:0] src_mode;
    logic [1:0] dst_mode;
    logic       intra_pan;
    logic       ack_req;
    logic       pending;
    logic       security;
    logic [2:0] frame_type;
  } fcf_s;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_PRE  = 6'h02,
    TX_SFD  = 6'h04,
    TX_LEN  = 6'h08,
    TX_DATA = 6'h10,
    TX_FCS  = 6'h20
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_SEARCH = 3'h1,
    RX_LEN    = 3'h2,
    RX_BODY   = 3'h4
  } rx_state_e;

  // Reflected CRC, bits taken least significant first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY_R) : (c >> 1);
    end
    return c;
  endfunction : crc_byte
endpackage : lowrate_frame_pkg

// *** design/frame_fifo.sv ***
// Small first-in first-out buffer with valid and ready on both sides
module frame_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = lowrate_frame_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= next_count;
      // Registered so the ready seen by the host comes straight from a flop
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule : frame_fifo

// *** design/lowrate_radio_frame_format.sv ***
// Transmit and receive frame formatter of the low-rate radio
// Summary of operation
// R1: Default header is four zero preamble bytes then delimiter 0xa7.
// R2: Synchronisation header always goes out before anything else.
// R3: Preamble length setting affects only transmission, never below default.
// R4: Delimiter comes from the two-byte sfd_pattern register.
// R5: Pattern carries two zero symbols, so preamble alone is six symbols.
// R6: Receive ignores low pattern nibbles equal 0xf, others must match.
// R7: 0xa7ff needs 0,7,a; 0xa70f needs 0,0,7,a; 0xa700 needs 0,0,0,7,a.
// R8: Preamble syncs symbols, delimiter aligns bytes, delimiter never stored.
// R9: Delimiter search runs only while no frame is being received; on hit, received bytes are written out.
// R10: Length counts MPDU bytes, excluding itself, including check bytes.
// R11: Length is seven bits, max 127; transmitted top bit is zero.
// R12: Length drives both directions; transmit flags underflow on missing bytes.
// R13: Host inserts and checks the sequence number; no hardware for it.
// R14: Frame control decoded: type, security, pending, ack, intra-PAN, modes.
// R15: Two check bytes follow payload, computed over MPDU only.
// R16: auto_fcs_en makes hardware generate and check; else the host does.
// R17: Check uses polynomial x16 + x12 + x5 + 1.
// R18: Transmit check held in its own 16-bit register, appended at length end.
// R19: Receive stores averaged 8-symbol signal strength in first check byte.
// R20: Last stored byte bits 6:0 hold 8-symbol average correlation.
// R21: Last stored byte bit 7 is one on check pass, zero on fail.
// R22: Delimiter detection gated by corr_detect_threshold, reset value 20.
// R23: Host writes the length byte first into transmit_buffer.
// R24: Length byte is written to receive_buffer before MPDU bytes.
// R25: Check register starts at zero per frame, bits least significant first.
// R26: Check bytes sent low byte first, right after payload, no gap.
module lowrate_radio_frame_format #(
  parameter int unsigned SYM_CYCLES = lowrate_frame_pkg::SYM_CYCLES,
  parameter int unsigned FIFO_DEPTH = lowrate_frame_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Register write ports and readback
  input  wire logic                    sfd_pattern_we,
  input  wire logic                    modem_ctrl_0_we,
  input  wire logic                    modem_ctrl_1_we,
  input  wire logic [15:0]             reg_wdata,
  output logic      [15:0]             sfd_pattern,
  output logic      [15:0]             modem_ctrl_0,
  output logic      [15:0]             modem_ctrl_1,
  // Transmit buffer fill and commands
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire logic [7:0]              tx_data,
  input  wire logic                    tx_start,
  input  wire logic                    tx_flush,
  // Transmit symbol stream and status
  output logic      [3:0]              tx_symbol,
  output logic                         tx_symbol_valid,
  output logic                         tx_active,
  output logic                         tx_sfd,
  output logic                         tx_underflow,
  // Receive symbol stream from the demodulator
  input  wire logic                    rx_sym_strobe,
  input  wire logic [3:0]              rx_symbol,
  input  wire logic [7:0]              rx_rssi,
  input  wire logic [6:0]              rx_corr,
  // Receive buffer write port and status
  output logic      [7:0]              rx_byte,
  output logic                         rx_byte_valid,
  output logic                         rx_sfd,
  output logic                         rx_crc_ok,
  output lowrate_frame_pkg::fcf_s      rx_fcf
);
  localparam int unsigned DW = $clog2(SYM_CYCLES);

  // Configuration fields
  wire [3:0] pre_sel  = modem_ctrl_0[lowrate_frame_pkg::PRE_LSB +: lowrate_frame_pkg::PRE_W];
  wire       auto_fcs_en = modem_ctrl_0[lowrate_frame_pkg::AUTO_FCS_BIT];
  wire [4:0] corr_detect_threshold = modem_ctrl_1[lowrate_frame_pkg::CORR_DETECT_THRESHOLD_LSB +: lowrate_frame_pkg::CORR_DETECT_THRESHOLD_W];
  // Short settings would break compliance, so clamp to the default
  wire [3:0] pre_eff  = (pre_sel < lowrate_frame_pkg::PRE_DEFAULT) ? lowrate_frame_pkg::PRE_DEFAULT : pre_sel; // R3
  wire [4:0] pre_last = {pre_eff, 1'b1}; // R5

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfd_pattern  <= lowrate_frame_pkg::SFD_PATTERN_RST; // R1
      modem_ctrl_0 <= lowrate_frame_pkg::MODEM_CTRL_0_RST;
      modem_ctrl_1 <= lowrate_frame_pkg::MODEM_CTRL_1_RST; // R22
    end else begin
      if (sfd_pattern_we) sfd_pattern <= reg_wdata; // R4
      if (modem_ctrl_0_we) modem_ctrl_0 <= reg_wdata;
      if (modem_ctrl_1_we) modem_ctrl_1 <= reg_wdata;
    end
  end

  function automatic logic [6:0] body_len(input logic [6:0] len, input logic fcs);
    if (!fcs) return len;
    return (len >= lowrate_frame_pkg::FCS_BYTES) ? len - lowrate_frame_pkg::FCS_BYTES : 7'h00;
  endfunction : body_len

  // Arrival order: newest symbol in h[3:0], the high nibble of the pattern
  function automatic logic sfd_match(input logic [19:0] h, input logic [15:0] p);
    logic ok;
    logic skip;
    int   zpos;
    ok   = 1'b1;
    skip = 1'b1;
    zpos = 4;
    for (int k = 0; k < 4; k++) begin
      if (skip && p[4*k +: 4] == lowrate_frame_pkg::IGNORE_NIB) begin
        zpos = 3 - k; // R6
      end else begin
        skip = 1'b0;
        if (h[4*(3-k) +: 4] != p[4*k +: 4]) ok = 1'b0; // R6
      end
    end
    if (h[4*zpos +: 4] != lowrate_frame_pkg::PRE_SYMBOL) ok = 1'b0; // R7
    return ok;
  endfunction : sfd_match

  // Symbol rate enable
  logic [DW-1:0] div_cnt;
  logic          sym_tick;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= '0;
      sym_tick <= 1'b0;
    end else begin
      sym_tick <= (div_cnt == DW'(SYM_CYCLES - 1));
      div_cnt  <= (div_cnt == DW'(SYM_CYCLES - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  // Transmit buffer: the formatter only pops when a byte is due, so the host stalls on tx_ready
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;

  frame_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_buffer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  lowrate_frame_pkg::tx_state_e tx_state;
  logic [4:0]  pre_cnt;
  logic [1:0]  sfd_idx;
  logic        nib_hi;
  logic [3:0]  hi_nib;
  logic [6:0]  data_left;
  logic        fcs_sel;
  logic        fcs_on;
  logic [15:0] tx_crc;

  wire        need_byte  = sym_tick && !nib_hi && (tx_state == lowrate_frame_pkg::TX_LEN ||
                                                   tx_state == lowrate_frame_pkg::TX_DATA);
  wire        underflow  = need_byte && !fifo_valid; // R12
  assign      fifo_pop   = need_byte && fifo_valid;
  wire [3:0]  sfd_nib    = sfd_pattern[4*sfd_idx +: 4];
  wire [3:0]  sfd_tx_nib = (sfd_nib == lowrate_frame_pkg::IGNORE_NIB) ? lowrate_frame_pkg::PRE_SYMBOL : sfd_nib;
  wire [7:0]  fcs_byte   = fcs_sel ? tx_crc[15:8] : tx_crc[7:0]; // R26
  wire [6:0]  first_body = body_len(fifo_data[6:0], fcs_on); // R10
  wire        tx_busy    = (tx_state != lowrate_frame_pkg::TX_IDLE);
  wire        after_body = fcs_on ? 1'b1 : 1'b0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state        <= lowrate_frame_pkg::TX_IDLE;
      pre_cnt         <= '0;
      sfd_idx         <= '0;
      nib_hi          <= 1'b0;
      hi_nib          <= '0;
      data_left       <= '0;
      fcs_sel         <= 1'b0;
      fcs_on          <= 1'b0;
      tx_crc          <= lowrate_frame_pkg::CRC_INIT;
      tx_symbol       <= '0;
      tx_symbol_valid <= 1'b0;
      tx_sfd          <= 1'b0;
      tx_underflow    <= 1'b0;
    end else begin
      tx_symbol_valid <= 1'b0;
      // A new underflow wins over a flush in the same cycle
      if (underflow) tx_underflow <= 1'b1; // R12
      else if (tx_flush) tx_underflow <= 1'b0;
      if (!tx_busy && tx_start && !tx_underflow) begin
        tx_state <= lowrate_frame_pkg::TX_PRE; // R2
        pre_cnt  <= '0;
        nib_hi   <= 1'b0;
        fcs_sel  <= 1'b0;
        fcs_on   <= auto_fcs_en; // R16
        tx_crc   <= lowrate_frame_pkg::CRC_INIT; // R25
      end else if (sym_tick && tx_busy) begin
        tx_symbol_valid <= 1'b1;
        case (tx_state)
          lowrate_frame_pkg::TX_PRE: begin
            tx_symbol <= lowrate_frame_pkg::PRE_SYMBOL; // R1
            pre_cnt   <= pre_cnt + 1'b1;
            if (pre_cnt == pre_last) begin
              tx_state <= lowrate_frame_pkg::TX_SFD;
              sfd_idx  <= '0;
            end
          end
          lowrate_frame_pkg::TX_SFD: begin
            tx_symbol <= sfd_tx_nib; // R4
            sfd_idx   <= sfd_idx + 1'b1;
            if (sfd_idx == 2'(lowrate_frame_pkg::SYNC_NIBBLES - 1)) begin
              tx_state <= lowrate_frame_pkg::TX_LEN;
              tx_sfd   <= 1'b1;
            end
          end
          lowrate_frame_pkg::TX_LEN, lowrate_frame_pkg::TX_DATA: begin
            if (!nib_hi) begin
              if (fifo_valid) begin
                tx_symbol <= fifo_data[3:0];
                hi_nib    <= fifo_data[7:4];
                nib_hi    <= 1'b1;
                if (tx_state == lowrate_frame_pkg::TX_LEN) begin
                  hi_nib    <= {1'b0, fifo_data[6:4]}; // R11
                  data_left <= first_body;
                end else begin
                  tx_crc <= lowrate_frame_pkg::crc_byte(tx_crc, fifo_data); // R15
                end
              end else begin
                // Frame is cut short; the symbol slot is left silent
                tx_symbol_valid <= 1'b0;
                tx_state        <= lowrate_frame_pkg::TX_IDLE; // R12
                tx_sfd          <= 1'b0;
              end
            end else begin
              tx_symbol <= hi_nib;
              nib_hi    <= 1'b0;
              if (tx_state == lowrate_frame_pkg::TX_DATA) data_left <= data_left - 1'b1;
              if ((tx_state == lowrate_frame_pkg::TX_LEN && data_left == '0) ||
                  (tx_state == lowrate_frame_pkg::TX_DATA && data_left == 7'h01)) begin
                tx_state <= after_body ? lowrate_frame_pkg::TX_FCS : lowrate_frame_pkg::TX_IDLE; // R18
                tx_sfd   <= after_body;
              end else begin
                tx_state <= lowrate_frame_pkg::TX_DATA;
              end
            end
          end
          lowrate_frame_pkg::TX_FCS: begin
            nib_hi <= !nib_hi;
            if (!nib_hi) begin
              tx_symbol <= fcs_byte[3:0]; // R26
            end else begin
              tx_symbol <= fcs_byte[7:4];
              fcs_sel   <= 1'b1;
              if (fcs_sel) begin
                tx_state <= lowrate_frame_pkg::TX_IDLE;
                tx_sfd   <= 1'b0;
              end
            end
          end
          default: begin
            tx_state <= lowrate_frame_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tx_active <= 1'b0;
    else tx_active <= tx_busy;
  end

  // Receive path
  lowrate_frame_pkg::rx_state_e rx_state;
  logic [15:0] hist;
  logic        rx_nib_hi;
  logic [3:0]  rx_lo;
  logic [6:0]  rx_left;
  logic [1:0]  rx_idx;
  logic [15:0] rx_crc;
  logic [3:0]  avg_cnt;
  logic [10:0] rssi_sum;
  logic [9:0]  corr_sum;
  logic        rx_fcs_on;

  wire        sfd_hit   = rx_sym_strobe && (rx_state == lowrate_frame_pkg::RX_SEARCH) &&
                          sfd_match({hist, rx_symbol}, sfd_pattern) &&
                          ({2'b00, corr_detect_threshold} <= rx_corr); // R22
  wire [7:0]  rx_full   = {rx_symbol, rx_lo};
  wire [15:0] crc_next  = lowrate_frame_pkg::crc_byte(rx_crc, rx_full); // R17
  wire        crc_pass  = (crc_next == 16'h0000); // R21
  wire        avg_take  = (avg_cnt < 4'(lowrate_frame_pkg::AVG_SYMBOLS));
  wire [7:0]  rssi_avg  = rssi_sum[10:3]; // R19
  wire [6:0]  corr_avg  = corr_sum[9:3]; // R20
  wire [7:0]  body_out  = !rx_fcs_on ? rx_full :
                          (rx_left == lowrate_frame_pkg::FCS_BYTES) ? rssi_avg : // R19
                          (rx_left == 7'h01) ? {crc_pass, corr_avg} : rx_full; // R20
  wire        byte_done = rx_sym_strobe && rx_nib_hi && (rx_state != lowrate_frame_pkg::RX_SEARCH);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state      <= lowrate_frame_pkg::RX_SEARCH;
      hist          <= '0;
      rx_nib_hi     <= 1'b0;
      rx_lo         <= '0;
      rx_left       <= '0;
      rx_idx        <= '0;
      rx_crc        <= lowrate_frame_pkg::CRC_INIT;
      avg_cnt       <= '0;
      rssi_sum      <= '0;
      corr_sum      <= '0;
      rx_fcs_on     <= 1'b0;
      rx_byte       <= '0;
      rx_byte_valid <= 1'b0;
      rx_sfd        <= 1'b0;
      rx_crc_ok     <= 1'b0;
      rx_fcf        <= '0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (rx_sym_strobe) hist <= {hist[11:0], rx_symbol}; // R9
      if (sfd_hit) begin
        // Delimiter itself is consumed here and never written out
        rx_state  <= lowrate_frame_pkg::RX_LEN; // R8
        rx_sfd    <= 1'b1;
        rx_nib_hi <= 1'b0;
        avg_cnt   <= '0;
        rssi_sum  <= '0;
        corr_sum  <= '0;
        rx_idx    <= '0;
        rx_fcs_on <= auto_fcs_en; // R16
        rx_crc    <= lowrate_frame_pkg::CRC_INIT; // R25
      end else if (rx_sym_strobe && rx_state != lowrate_frame_pkg::RX_SEARCH) begin
        if (avg_take) begin
          avg_cnt  <= avg_cnt + 1'b1;
          rssi_sum <= rssi_sum + 11'(rx_rssi); // R19
          corr_sum <= corr_sum + 10'(rx_corr); // R20
        end
        rx_nib_hi <= !rx_nib_hi;
        if (!rx_nib_hi) rx_lo <= rx_symbol;
      end
      if (byte_done) begin
        rx_byte_valid <= 1'b1;
        if (rx_state == lowrate_frame_pkg::RX_LEN) begin
          rx_byte <= rx_full; // R24
          rx_left <= rx_full[6:0]; // R11
          if (rx_full[6:0] == '0) begin
            rx_state <= lowrate_frame_pkg::RX_SEARCH;
            rx_sfd   <= 1'b0;
          end else begin
            rx_state <= lowrate_frame_pkg::RX_BODY; // R10
          end
        end else begin
          rx_byte <= body_out;
          rx_crc  <= crc_next; // R15
          rx_left <= rx_left - 1'b1;
          if (rx_idx != 2'h2) rx_idx <= rx_idx + 1'b1;
          if (rx_idx == 2'h0) begin
            {rx_fcf.intra_pan, rx_fcf.ack_req, rx_fcf.pending, rx_fcf.security, rx_fcf.frame_type} <= rx_full[6:0]; // R14
          end
          if (rx_idx == 2'h1) begin
            rx_fcf.dst_mode <= rx_full[3:2]; // R14
            rx_fcf.src_mode <= rx_full[7:6]; // R14
          end
          if (rx_left == 7'h01) begin
            rx_state  <= lowrate_frame_pkg::RX_SEARCH; // R9
            rx_sfd    <= 1'b0;
            rx_crc_ok <= crc_pass; // R21
          end
        end
      end
    end
  end
endmodule : lowrate_radio_frame_format

// *** dv/frame_format_asserts.sv ***
// Port checker of the frame formatter
module frame_format_asserts #(
  parameter int unsigned SYM_CYCLES = 4
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Registers
  input wire logic        sfd_pattern_we,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] sfd_pattern,
  // Transmit side
  input wire logic        tx_start,
  input wire logic        tx_flush,
  input wire logic [3:0]  tx_symbol,
  input wire logic        tx_symbol_valid,
  input wire logic        tx_active,
  input wire logic        tx_sfd,
  input wire logic        tx_underflow,
  // Receive side
  input wire logic        rx_sym_strobe,
  input wire logic        rx_byte_valid,
  input wire logic        rx_sfd
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_halted;
    ##2 !tx_active;
  endsequence
  sfd_write_a: assert property (sfd_pattern_we |=> sfd_pattern == $past(reg_wdata))
    else $error("delimiter register write lost");
  sfd_end_a: assert property ($rose(tx_sfd) |-> tx_symbol_valid && tx_symbol == sfd_pattern[15:12])
    else $error("delimiter end flag off its symbol");
  sym_gap_a: assert property (tx_symbol_valid && tx_sfd && $past(tx_sfd) |-> $past(tx_symbol_valid, SYM_CYCLES))
    else $error("gap in transmitted symbols");
  flow_sticky_a: assert property (tx_underflow && !tx_flush |=> tx_underflow)
    else $error("underflow flag dropped");
  flow_block_a: assert property (tx_underflow && tx_start |-> s_halted)
    else $error("start taken during underflow");
  rx_sfd_start_a: assert property ($rose(rx_sfd) |-> $past(rx_sym_strobe))
    else $error("frame start without symbol");
  rx_answer_a: assert property (rx_byte_valid |-> $past(rx_sym_strobe) && !$past(rx_byte_valid))
    else $error("stored byte without symbol");
  rx_frame_only_a: assert property (!rx_sfd && !$past(rx_sfd) |-> !rx_byte_valid)
    else $error("byte stored outside a frame");
endmodule : frame_format_asserts

bind lowrate_radio_frame_format frame_format_asserts #(.SYM_CYCLES(SYM_CYCLES)) chk (.ref_clk, .rst_n,
  .sfd_pattern_we, .reg_wdata, .sfd_pattern, .tx_start, .tx_flush, .tx_symbol, .tx_symbol_valid, .tx_active,
  .tx_sfd, .tx_underflow, .rx_sym_strobe, .rx_byte_valid, .rx_sfd);

// *** dv/remote_radio_model.sv ***
// Remote transmitter feeding demodulated symbols
module remote_radio_model (
  // Clock
  input  wire logic       ref_clk,
  // Symbol stream
  output logic            rx_sym_strobe,
  output logic      [3:0] rx_symbol,
  output logic      [7:0] rx_rssi,
  output logic      [6:0] rx_corr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_sym_strobe = 1'b0;
    rx_symbol     = 4'h0;
    rx_rssi       = 8'h00;
    rx_corr       = 7'h00;
  end
  task automatic put_sym(input logic [3:0] s, input int gap);
    @(negedge ref_clk);
    rx_sym_strobe = 1'b1;
    rx_symbol     = s;
    @(negedge ref_clk);
    rx_sym_strobe = 1'b0;
    // Stale symbol must not look valid
    rx_symbol     = ~s;
    repeat (gap) @(negedge ref_clk);
  endtask : put_sym
  // Noise, zeros, delimiter tail, bytes low nibble first
  task automatic send(input logic [7:0] q[$], input int nz, input logic [6:0] corr, input logic [7:0] rssi,
                      input int gap);
    rx_corr = corr;
    rx_rssi = rssi;
    put_sym(4'h5, gap);
    repeat (nz) put_sym(4'h0, gap);
    put_sym(4'h7, gap);
    put_sym(4'ha, gap);
    foreach (q[i]) begin
      put_sym(q[i][3:0], gap);
      put_sym(q[i][7:4], gap);
    end
  endtask : send
endmodule : remote_radio_model

// *** dv/tb_lowrate_radio_frame_format.sv ***
// Self-checking bench of the frame formatter
module tb_lowrate_radio_frame_format;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, sfd_pattern_we, modem_ctrl_0_we, modem_ctrl_1_we, tx_valid, tx_ready, tx_start;
  logic tx_flush, tx_symbol_valid, tx_active, tx_sfd, tx_underflow, rx_sym_strobe, rx_byte_valid, rx_sfd;
  logic rx_crc_ok;
  logic [15:0] reg_wdata, sfd_pattern, modem_ctrl_0, modem_ctrl_1, crc;
  logic [7:0]  tx_data, rx_rssi, rx_byte, rs;
  logic [3:0]  tx_symbol, rx_symbol;
  logic [6:0]  rx_corr;
  logic [31:0] seed, t;
  lowrate_frame_pkg::fcf_s rx_fcf;
  int bad_count, n_tests, cyc;
  logic [3:0] exp_tx[$];
  logic [7:0] exp_rx[$], fr[$];
  // Pattern, zeros, frame kind (0 none, 1 good, 2 bad check), auto check, correlation
  logic [31:0] tab[7] = '{32'ha7ff_11b0, 32'ha70f_21b0, 32'ha700_31b0, 32'ha700_20b0, 32'ha70f_2093,
                          32'ha70f_22b0, 32'ha70f_2130};

  lowrate_radio_frame_format #(.SYM_CYCLES(4), .FIFO_DEPTH(4)) DUT (.ref_clk, .rst_n, .sfd_pattern_we,
    .modem_ctrl_0_we, .modem_ctrl_1_we, .reg_wdata, .sfd_pattern, .modem_ctrl_0, .modem_ctrl_1, .tx_valid,
    .tx_ready, .tx_data, .tx_start, .tx_flush, .tx_symbol, .tx_symbol_valid, .tx_active, .tx_sfd, .tx_underflow,
    .rx_sym_strobe, .rx_symbol, .rx_rssi, .rx_corr, .rx_byte, .rx_byte_valid, .rx_sfd, .rx_crc_ok, .rx_fcf);
  remote_radio_model peer (.ref_clk, .rx_sym_strobe, .rx_symbol, .rx_rssi, .rx_corr);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [2:0] sel, input logic [15:0] v);
    @(negedge ref_clk);
    reg_wdata = v;
    {modem_ctrl_1_we, modem_ctrl_0_we, sfd_pattern_we} = sel;
    @(negedge ref_clk);
    {modem_ctrl_1_we, modem_ctrl_0_we, sfd_pattern_we} = 3'h0;
  endtask : wr
  // Length byte then three random bytes, check value over the last three
  task automatic build(input logic [7:0] len);
    fr = {len, rnd(), rnd(), rnd()};
    crc = 16'h0000;
    for (int i = 1; i < 4; i++)
      for (int b = 0; b < 8; b++)
        crc = (crc[0] ^ fr[i][b]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
  endtask : build
  task automatic tx_put(input logic [7:0] b);
    @(negedge ref_clk);
    tx_valid = 1'b1;
    tx_data  = b;
    do @(posedge ref_clk); while (tx_ready !== 1'b1);
    @(negedge ref_clk);
    tx_valid = 1'b0;
  endtask : tx_put
  task automatic tx_exp(input logic [7:0] b);
    exp_tx.push_back(b[3:0]);
    exp_tx.push_back(b[7:4]);
  endtask : tx_exp
  task automatic tx_hdr(input int n);
    repeat (n) exp_tx.push_back(4'h0);
    tx_exp(8'h00);
    tx_exp(8'ha7);
  endtask : tx_hdr
  task automatic tx_run();
    @(negedge ref_clk);
    tx_start = 1'b1;
    @(negedge ref_clk);
    tx_start = 1'b0;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 2000 && tx_active; i++)
      @(negedge ref_clk);
  endtask : tx_run

  always @(posedge ref_clk) begin
    if (tx_symbol_valid === 1'b1)
      chk(tx_symbol, exp_tx.size() ? exp_tx.pop_front() : 4'hx);
    if (rx_byte_valid === 1'b1)
      chk(rx_byte, exp_rx.size() ? exp_rx.pop_front() : 8'hxx);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    {rst_n, sfd_pattern_we, modem_ctrl_0_we, modem_ctrl_1_we, tx_valid, tx_start, tx_flush} = 7'h00;
    reg_wdata = 16'h0000;
    tx_data = 8'h00;
    seed = 32'h6f71;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk(sfd_pattern, 16'ha70f);
    chk(modem_ctrl_0, 16'h0022);
    chk(modem_ctrl_1[10:6], 5'h14);
    wr(3'h4, 16'h0500);
    chk(modem_ctrl_1, 16'h0500);
    // Setting below default must still give six zeros
    wr(3'h2, 16'h0020);
    // Reserved length bit set by the host must go out as zero
    build(8'h85);
    foreach (fr[i]) tx_put(fr[i]);
    @(negedge ref_clk);
    chk(tx_ready, 1'b0);
    tx_hdr(6);
    foreach (fr[i]) tx_exp(fr[i] & {i > 0, 7'h7f});
    tx_exp(crc[7:0]);
    tx_exp(crc[15:8]);
    tx_run();
    // Longer preamble, one byte short of the announced length
    wr(3'h2, 16'h0023);
    build(8'h06);
    foreach (fr[i]) tx_put(fr[i]);
    tx_hdr(8);
    foreach (fr[i]) tx_exp(fr[i]);
    tx_run();
    chk(tx_underflow, 1'b1);
    chk(tx_sfd, 1'b0);
    tx_run();
    chk(tx_active, 1'b0);
    tx_flush = 1'b1;
    @(negedge ref_clk);
    tx_flush = 1'b0;
    chk(tx_underflow, 1'b0);
    foreach (tab[k]) begin
      t = tab[k];
      wr(3'h1, t[31:16]);
      wr(3'h2, t[7] ? 16'h0022 : 16'h0002);
      build(8'h05);
      crc = crc ^ {15'h0000, t[9]};
      rs = rnd();
      if (t[9:8] != 2'h0) begin
        foreach (fr[i]) exp_rx.push_back(fr[i]);
        exp_rx.push_back(t[7] ? rs : crc[7:0]);
        exp_rx.push_back(t[7] ? {t[9:8] == 2'h1, t[6:0]} : crc[15:8]);
      end
      fr.push_back(crc[7:0]);
      fr.push_back(crc[15:8]);
      peer.send(fr, int'(t[15:12]), t[6:0], rs, k % 3);
      repeat (6) @(negedge ref_clk);
      chk(16'(exp_rx.size()), 16'h0000);
      if (t[9:8] != 2'h0)
        chk(rx_fcf, {fr[2][7:6], fr[2][3:2], fr[1][6:0]});
      if (t[9:8] != 2'h0 && t[7])
        chk(rx_crc_ok, t[9:8] == 2'h1);
    end
    chk(16'(exp_tx.size()), 16'h0000);
    wrap_up();
  end
endmodule : tb_lowrate_radio_frame_format
